// ### rtl/clp_pkg.sv
package clp_pkg;
	localparam int unsigned CLK_HZ   = 20_000_000;
	localparam int unsigned TICK_US  = 5000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

	localparam int MAG_W  = 16;
	localparam int TMR_W  = 19;
	localparam int CNT_W  = 16;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int COND_W = 3;

	// Hysteresis as a ratio, compared by cross multiplication
	localparam logic [6:0] HYS_NUM = 7'h61;
	localparam logic [6:0] HYS_DEN = 7'h64;

	// Magnitudes and thresholds in units of 0.01 x In
	localparam logic [MAG_W-1:0] LOW_DEF  = 16'h0014;
	localparam logic [MAG_W-1:0] HIGH_DEF = 16'h0078;
	localparam logic [MAG_W-1:0] OVER_DEF = 16'h00c8;

	// Timer settings are held in ticks
	localparam int unsigned START_DELAY_MS = 10000;
	localparam int unsigned MAX_INRUSH_MS  = 30000;
	localparam int unsigned MIN_HOLD_MS    = 40;
	localparam logic [TMR_W-1:0] START_DEF = TMR_W'(START_DELAY_MS * 1000 / TICK_US);
	localparam logic [TMR_W-1:0] MAXI_DEF  = TMR_W'(MAX_INRUSH_MS * 1000 / TICK_US);
	localparam logic [TMR_W-1:0] MINH_DEF  = TMR_W'(MIN_HOLD_MS * 1000 / TICK_US);

	// Byte offsets on the register bus
	localparam logic [ADDR_W-1:0] OFS_LOW    = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_HIGH   = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_OVER   = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_START  = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_MAXI   = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_MINH   = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_ACTCNT = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_BLKCNT = 6'h20;

	// Status word fields
	localparam int ST_COND_LSB = 0;
	localparam int ST_ACT      = 3;
	localparam int ST_BLK      = 4;
	localparam int ST_LOW      = 5;
	localparam int ST_HIGH     = 6;
	localparam int ST_OVER     = 7;
	localparam int ST_BLKIN    = 8;

	// Threshold kinds and event indices
	localparam int TH_LOW  = 0;
	localparam int TH_HIGH = 1;
	localparam int TH_OVER = 2;
	localparam int TH_N    = 3;
	localparam int PH_N    = 3;
	localparam int EV_LOW    = 0;
	localparam int EV_HIGH   = 1;
	localparam int EV_NORMAL = 2;
	localparam int EV_OVER   = 3;
	localparam int EV_ACT    = 4;
	localparam int EV_BLK    = 5;
	localparam int EV_N      = 6;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_DELAY   = 2'b01,
		ST_ACTIVE  = 2'b10,
		ST_BLOCKED = 2'b11
	} clp_state_t;

	typedef enum logic [COND_W-1:0] {
		COND_NORMAL   = 3'b000,
		COND_CURR_LOW = 3'b001,
		COND_OVER_ON  = 3'b010,
		COND_CLP_ON   = 3'b011,
		COND_CLP_BLK  = 3'b100
	} clp_cond_t;

	typedef struct packed {
		logic [MAG_W-1:0] phase_a_magnitude;
		logic [MAG_W-1:0] phase_b_magnitude;
		logic [MAG_W-1:0] phase_c_magnitude;
	} clp_phase_t;

	typedef struct packed {
		logic [MAG_W-1:0] low_threshold;
		logic [MAG_W-1:0] high_threshold;
		logic [MAG_W-1:0] over_threshold;
		logic [TMR_W-1:0] start_delay;
		logic [TMR_W-1:0] max_inrush_time;
		logic [TMR_W-1:0] min_hold_time;
	} clp_cfg_t;
endpackage

// ### rtl/clp_cmp.sv
`timescale 1ns/1ps
module clp_cmp #(
	parameter int MAG_W = clp_pkg::MAG_W
) (
	input  logic             clk,
	input  logic             resetn,
	input  logic             ce,
	input  logic             sample,
	input  logic [MAG_W-1:0] mag,
	input  logic [MAG_W-1:0] thr,
	output logic             above_q
);
	import clp_pkg::*;

	logic [MAG_W+6:0] mag_s;
	logic [MAG_W+6:0] thr_s;

	// Cross multiply so no divider is needed
	assign mag_s = mag * HYS_DEN;
	assign thr_s = thr * HYS_NUM;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			above_q <= 1'b0;
		end else if (ce && sample) begin
			if (mag > thr) begin
				above_q <= 1'b1;
			end else if (mag_s < thr_s) begin
				above_q <= 1'b0;
			end
		end
	end
endmodule

// ### rtl/clp_detector.sv
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module clp_detector
	import clp_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = clp_pkg::TICK_CYC
) (
	input  logic                       clk,
	input  logic                       resetn,
	input  logic                       ce,
	input  clp_pkg::clp_phase_t        phases,
	input  logic                       block_in,
	input  logic [clp_pkg::ADDR_W-1:0] avs_address,
	input  logic                       avs_read,
	input  logic                       avs_write,
	input  logic [clp_pkg::DATA_W-1:0] avs_writedata,
	output logic [clp_pkg::DATA_W-1:0] avs_readdata,
	output logic                       avs_waitrequest,
	output logic                       cold_load_active,
	output logic                       blocked,
	output clp_pkg::clp_cond_t         condition_status,
	output logic [clp_pkg::EV_N-1:0]   event_on,
	output logic [clp_pkg::EV_N-1:0]   event_off
);
	import clp_pkg::*;

	localparam int DIV_W = $clog2(TICK_CYCLES);

	logic [DIV_W-1:0]  div_q;
	logic              tick_q;
	logic              eval_q;
	logic              blk_m_q;
	logic              blk_s_q;
	logic              blk_t_q;
	logic [MAG_W-1:0]  mags [PH_N];
	logic [MAG_W-1:0]  thrs [TH_N];
	logic [PH_N-1:0]   above [TH_N];
	logic              low_c;
	logic              high_c;
	logic              over_c;
	clp_cfg_t          cfg_q;
	clp_state_t        state_q;
	logic [TMR_W-1:0]  tmr_q;
	logic [TMR_W-1:0]  inr_q;
	logic              pickup;
	logic              release_c;
	logic [EV_N-1:0]   lvl;
	logic [EV_N-1:0]   lvl_q;
	logic [CNT_W-1:0]  act_cnt_q;
	logic [CNT_W-1:0]  blk_cnt_q;
	logic [DATA_W-1:0] rd_d;
	logic              wr_acc;

	function automatic logic reg_hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs
	);
		return a == ofs;
	endfunction

	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_q  <= '0;
			tick_q <= 1'b0;
			eval_q <= 1'b0;
		end else if (ce) begin
			tick_q <= (div_q == DIV_W'(TICK_CYCLES - 1));
			eval_q <= tick_q;
			if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	// Block pin crosses in from outside the clock domain
	always_ff @(posedge clk) begin
		if (!resetn) begin
			blk_m_q <= 1'b0;
			blk_s_q <= 1'b0;
		end else if (ce) begin
			blk_m_q <= block_in;
			blk_s_q <= blk_m_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			blk_t_q <= 1'b0;
		end else if (ce && tick_q) begin
			blk_t_q <= blk_s_q;
		end
	end

	assign mags[0] = phases.phase_a_magnitude;
	assign mags[1] = phases.phase_b_magnitude;
	assign mags[2] = phases.phase_c_magnitude;
	assign thrs[TH_LOW]  = cfg_q.low_threshold;
	assign thrs[TH_HIGH] = cfg_q.high_threshold;
	assign thrs[TH_OVER] = cfg_q.over_threshold;

	for (genvar k = 0; k < TH_N; k++) begin : g_thr
		for (genvar p = 0; p < PH_N; p++) begin : g_ph
			clp_cmp #(
				.MAG_W (MAG_W)
			) u_cmp (
				.clk     (clk),
				.resetn  (resetn),
				.ce      (ce),
				.sample  (tick_q),
				.mag     (mags[p]),
				.thr     (thrs[k]),
				.above_q (above[k][p])
			);
		end
	end

	assign low_c  = ~|above[TH_LOW];
	assign high_c = &above[TH_HIGH];
	assign over_c = |above[TH_OVER];

	// Pick-up and release decisions for the current tick
	always_comb begin
		pickup    = 1'b0;
		release_c = 1'b0;
		case (state_q)
			ST_IDLE: begin
				pickup = low_c && (cfg_q.start_delay == '0);
			end
			ST_DELAY: begin
				pickup = low_c && (tmr_q >= cfg_q.start_delay);
			end
			ST_ACTIVE: begin
				release_c = over_c || blk_t_q
					|| (high_c && (inr_q >= cfg_q.max_inrush_time))
					|| (!high_c && !low_c && (tmr_q >= cfg_q.min_hold_time));
			end
			default: begin
				pickup    = 1'b0;
				release_c = 1'b0;
			end
		endcase
	end

	// Main sequence, one step per processing tick
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q          <= ST_IDLE;
			tmr_q            <= '0;
			inr_q            <= '0;
			cold_load_active <= 1'b0;
			blocked          <= 1'b0;
		end else if (ce && eval_q) begin
			if (pickup) begin
				tmr_q <= '0;
				inr_q <= '0;
				if (blk_t_q) begin
					state_q <= ST_BLOCKED;
					blocked <= 1'b1;
				end else begin
					state_q          <= ST_ACTIVE;
					cold_load_active <= 1'b1;
				end
			end else begin
				case (state_q)
					ST_IDLE: begin
						if (low_c) begin
							state_q <= ST_DELAY;
							tmr_q   <= TMR_W'(1);
						end
					end
					ST_DELAY: begin
						if (!low_c) begin
							state_q <= ST_IDLE;
							tmr_q   <= '0;
						end else begin
							tmr_q <= tmr_q + 1'b1;
						end
					end
					ST_ACTIVE: begin
						if (release_c) begin
							state_q          <= ST_IDLE;
							cold_load_active <= 1'b0;
							tmr_q            <= '0;
							inr_q            <= '0;
						end else if (high_c) begin
							inr_q <= inr_q + 1'b1;
							tmr_q <= '0;
						end else begin
							inr_q <= '0;
							if (!low_c) begin
								tmr_q <= tmr_q + 1'b1;
							end
						end
					end
					ST_BLOCKED: begin
						// Nothing further until block or low ends
						if (!blk_t_q || !low_c) begin
							state_q <= ST_IDLE;
							blocked <= 1'b0;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			condition_status <= COND_NORMAL;
		end else if (ce) begin
			if (cold_load_active) begin
				condition_status <= COND_CLP_ON;
			end else if (blocked) begin
				condition_status <= COND_CLP_BLK;
			end else if (over_c) begin
				condition_status <= COND_OVER_ON;
			end else if (low_c) begin
				condition_status <= COND_CURR_LOW;
			end else begin
				condition_status <= COND_NORMAL;
			end
		end
	end

	assign lvl[EV_LOW]    = low_c;
	assign lvl[EV_HIGH]   = high_c;
	assign lvl[EV_NORMAL] = !low_c && !high_c && !over_c;
	assign lvl[EV_OVER]   = over_c;
	assign lvl[EV_ACT]    = cold_load_active;
	assign lvl[EV_BLK]    = blocked;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			lvl_q     <= '0;
			event_on  <= '0;
			event_off <= '0;
		end else if (ce) begin
			lvl_q     <= lvl;
			event_on  <= lvl & ~lvl_q;
			event_off <= ~lvl & lvl_q;
		end
	end

	// Writes land on the edge that sees waitrequest low
	assign wr_acc = avs_write && !avs_waitrequest;

	// counters, a count in the clear cycle survives
	always_ff @(posedge clk) begin
		if (!resetn) begin
			act_cnt_q <= '0;
			blk_cnt_q <= '0;
		end else if (ce) begin
			if (wr_acc && reg_hit(avs_address, OFS_ACTCNT)) begin
				act_cnt_q <= CNT_W'(event_on[EV_ACT]);
			end else if (event_on[EV_ACT]) begin
				act_cnt_q <= act_cnt_q + 1'b1;
			end
			if (wr_acc && reg_hit(avs_address, OFS_BLKCNT)) begin
				blk_cnt_q <= CNT_W'(event_on[EV_BLK]);
			end else if (event_on[EV_BLK]) begin
				blk_cnt_q <= blk_cnt_q + 1'b1;
			end
		end
	end

	// settings apply on the next tick
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_q.low_threshold   <= LOW_DEF;
			cfg_q.high_threshold  <= HIGH_DEF;
			cfg_q.over_threshold  <= OVER_DEF;
			cfg_q.start_delay     <= START_DEF;
			cfg_q.max_inrush_time <= MAXI_DEF;
			cfg_q.min_hold_time   <= MINH_DEF;
		end else if (ce && wr_acc) begin
			if (reg_hit(avs_address, OFS_LOW)) begin
				cfg_q.low_threshold <= avs_writedata[MAG_W-1:0];
			end
			if (reg_hit(avs_address, OFS_HIGH)) begin
				cfg_q.high_threshold <= avs_writedata[MAG_W-1:0];
			end
			if (reg_hit(avs_address, OFS_OVER)) begin
				cfg_q.over_threshold <= avs_writedata[MAG_W-1:0];
			end
			if (reg_hit(avs_address, OFS_START)) begin
				cfg_q.start_delay <= avs_writedata[TMR_W-1:0];
			end
			if (reg_hit(avs_address, OFS_MAXI)) begin
				cfg_q.max_inrush_time <= avs_writedata[TMR_W-1:0];
			end
			if (reg_hit(avs_address, OFS_MINH)) begin
				cfg_q.min_hold_time <= avs_writedata[TMR_W-1:0];
			end
		end
	end

	// Read mux, unmapped offsets read as zero
	always_comb begin
		rd_d = '0;
		case (avs_address)
			OFS_LOW:    rd_d[MAG_W-1:0] = cfg_q.low_threshold;
			OFS_HIGH:   rd_d[MAG_W-1:0] = cfg_q.high_threshold;
			OFS_OVER:   rd_d[MAG_W-1:0] = cfg_q.over_threshold;
			OFS_START:  rd_d[TMR_W-1:0] = cfg_q.start_delay;
			OFS_MAXI:   rd_d[TMR_W-1:0] = cfg_q.max_inrush_time;
			OFS_MINH:   rd_d[TMR_W-1:0] = cfg_q.min_hold_time;
			OFS_STATUS: begin
				rd_d[ST_COND_LSB +: COND_W] = condition_status;
				rd_d[ST_ACT]                = cold_load_active;
				rd_d[ST_BLK]                = blocked;
				rd_d[ST_LOW]                = low_c;
				rd_d[ST_HIGH]               = high_c;
				rd_d[ST_OVER]               = over_c;
				rd_d[ST_BLKIN]              = blk_t_q;
			end
			OFS_ACTCNT: rd_d[CNT_W-1:0] = act_cnt_q;
			OFS_BLKCNT: rd_d[CNT_W-1:0] = blk_cnt_q;
			default:    rd_d = '0;
		endcase
	end

	// Fixed one wait state keeps read data registered
	always_ff @(posedge clk) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
		end else if (ce) begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rd_d;
			end
		end
	end
endmodule

// ### verif/clp_meas_model.sv
`timescale 1ns/1ps
module clp_meas_model
	import clp_pkg::*;
#(
	parameter int unsigned TICK = 8
) (
	input  logic                clk,
	input  logic                resetn,
	input  clp_pkg::clp_phase_t cmd_mag,
	input  logic                cmd_blk,
	output clp_pkg::clp_phase_t phases,
	output logic                block_in
);
	int unsigned cnt;

	always_ff @(posedge clk) begin
		cnt <= (cnt + 1 >= TICK) ? 0 : cnt + 1;
		if (!resetn || cnt == 0)
			phases <= cmd_mag;
	end

	always_ff @(posedge clk)
		block_in <= cmd_blk;
endmodule

// ### verif/clp_detector_chk.sv
`timescale 1ns/1ps
module clp_detector_chk
	import clp_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 8
) (
	input logic                       clk,
	input logic                       resetn,
	input logic                       ce,
	input clp_pkg::clp_phase_t        phases,
	input logic                       block_in,
	input logic [clp_pkg::ADDR_W-1:0] avs_address,
	input logic                       avs_read,
	input logic                       avs_write,
	input logic [clp_pkg::DATA_W-1:0] avs_writedata,
	input logic [clp_pkg::DATA_W-1:0] avs_readdata,
	input logic                       avs_waitrequest,
	input logic                       cold_load_active,
	input logic                       blocked,
	input clp_pkg::clp_cond_t         condition_status,
	input logic [clp_pkg::EV_N-1:0]   event_on,
	input logic [clp_pkg::EV_N-1:0]   event_off
);
	logic any_over;

	// Bounds below assume the short tick used in simulation
	assign any_over = phases.phase_a_magnitude > OVER_DEF || phases.phase_b_magnitude > OVER_DEF
		|| phases.phase_c_magnitude > OVER_DEF;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_bus_ans;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");
	property p_excl;
		!(cold_load_active && blocked);
	endproperty
	a_excl: assert property (p_excl) else $error("active and blocked together");
	property p_over;
		any_over && cold_load_active |-> ##[0:20] !cold_load_active;
	endproperty
	a_over: assert property (p_over) else $error("over did not release");
	property p_blk;
		$rose(block_in) && cold_load_active |-> ##[1:24] !cold_load_active;
	endproperty
	a_blk: assert property (p_blk) else $error("block did not release");
	property p_act_st;
		$rose(cold_load_active) |=> condition_status == COND_CLP_ON;
	endproperty
	a_act_st: assert property (p_act_st) else $error("status not active");
	property p_blk_st;
		$rose(blocked) |=> condition_status == COND_CLP_BLK && event_on[EV_BLK];
	endproperty
	a_blk_st: assert property (p_blk_st) else $error("status not blocked");
	property p_ev_on;
		$rose(cold_load_active) |=> event_on[EV_ACT] ##1 !event_on[EV_ACT];
	endproperty
	a_ev_on: assert property (p_ev_on) else $error("no activation event");
	property p_ev_off;
		$fell(cold_load_active) |=> event_off[EV_ACT];
	endproperty
	a_ev_off: assert property (p_ev_off) else $error("no release event");
	property p_tick;
		$changed(cold_load_active) |=> $stable(cold_load_active) [*7];
	endproperty
	a_tick: assert property (p_tick) else $error("change off the tick");

	property p_freeze;
		!ce |=> $stable(cold_load_active) && $stable(blocked) && $stable(condition_status);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	c_act: cover property ($rose(cold_load_active));
	c_blk: cover property ($rose(blocked));
	c_over: cover property (any_over && cold_load_active);
endmodule

bind clp_detector clp_detector_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk),
	.resetn(resetn), .ce(ce), .phases(phases), .block_in(block_in), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.cold_load_active(cold_load_active), .blocked(blocked),
	.condition_status(condition_status), .event_on(event_on), .event_off(event_off));

// ### verif/clp_detector_bench.sv
`timescale 1ns/1ps
module clp_detector_bench;
	import clp_pkg::*;
	localparam int TK    = 8;
	localparam int LIMIT = 6000;
	typedef struct packed {
		logic [1:0] v;
		int         lo;
		int         hi;
	} clp_note_t;
	logic              clk, resetn, ce, avs_read, avs_write, avs_waitrequest;
	logic              block_in, cmd_blk, cold_load_active, blocked;
	logic [ADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata, seed;
	logic [1:0]        prev;
	clp_phase_t        phases, cmd_mag;
	int                cyc, n_mismatch, compares, n_act, n_blk;
	clp_note_t         oq[$];
	logic [DATA_W-1:0] rq[$];

	clp_meas_model #(.TICK(TK)) u_meas (.clk(clk), .resetn(resetn), .cmd_mag(cmd_mag),
		.cmd_blk(cmd_blk), .phases(phases), .block_in(block_in));
	clp_detector #(.TICK_CYCLES(TK)) DUT (.clk(clk), .resetn(resetn), .ce(ce), .phases(phases),
		.block_in(block_in), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cold_load_active(cold_load_active),
		.blocked(blocked), .condition_status(), .event_on(), .event_off());

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic bad(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_mismatch++;
		$display("BAD %s expected %h seen %h", nm, e, g);
	endtask

	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
			bad("readdata", e, g);
	endtask

	task automatic cmp_lvl(input logic [1:0] g);
		clp_note_t n;
		compares++;
		if (oq.size() == 0)
			bad("outputs", 32'h0, 32'(g));
		else begin
			n = oq.pop_front();
			if (g !== n.v || cyc < n.lo || cyc > n.hi)
				bad("outputs in window", 32'(n.v), 32'(g));
		end
	endtask

	// Watches results and takes the oldest note for each
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			cmp_rd(rq[0], avs_readdata);
			void'(rq.pop_front());
		end
		if (resetn === 1'b1 && {blocked, cold_load_active} !== prev) begin
			prev = {blocked, cold_load_active};
			cmp_lvl(prev);
		end
		if (cyc == LIMIT) begin
			bad("timeout", 32'(LIMIT), 32'(cyc));
			test_done;
		end
	end

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= ~w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		rq.push_back(e);
		bus(1'b0, a, '0);
	endtask

	// Window opens one tick early and closes two ticks plus four cycles late: measurement and decision ticks are not aligned
	task automatic await(input logic [1:0] v, input int n);
		oq.push_back('{v, cyc + (n - 1) * TK, cyc + (n + 2) * TK + 4});
		n_act += int'(v == 2'b01);
		n_blk += int'(v == 2'b10);
		while (oq.size() != 0)
			@(posedge clk);
	endtask

	function automatic clp_phase_t mk(input int base, input int span);
		logic [MAG_W-1:0] m [3];
		for (int i = 0; i < 3; i++) begin
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
			m[i] = MAG_W'(base + int'(seed[7:0]) % span);
		end
		return '{m[0], m[1], m[2]};
	endfunction

	task automatic put(input clp_phase_t p);
		@(posedge clk);
		cmd_mag <= p;
	endtask

	initial begin
		seed          = 32'hc2316dce;
		resetn        = 1'b0;
		ce            = 1'b1;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_address   = '0;
		avs_writedata = '0;
		cmd_blk       = 1'b0;
		cmd_mag       = '{16'h0032, 16'h0032, 16'h0032};
		prev          = 2'b00;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd(OFS_LOW, 32'(LOW_DEF));
		rd(OFS_HIGH, 32'(HIGH_DEF));
		rd(OFS_OVER, 32'(OVER_DEF));
		rd(OFS_START, 32'(START_DEF));
		rd(OFS_MAXI, 32'(MAXI_DEF));
		rd(OFS_MINH, 32'(MINH_DEF));
		bus(1'b1, OFS_STATUS, 32'h1ff);
		rd(OFS_STATUS, 32'h0);
		rd(6'h3c, 32'h0);
		bus(1'b1, OFS_START, 32'h3);
		bus(1'b1, OFS_MAXI, 32'h4);
		bus(1'b1, OFS_MINH, 32'h2);
		rd(OFS_START, 32'h3);
		$display("test registers done");
		put('{16'h0005, 16'h0005, 16'h003c});
		repeat (6 * TK) @(posedge clk);
		put(mk(0, 15));
		repeat (2 * TK) @(posedge clk);
		put(mk(30, 80));
		repeat (4 * TK) @(posedge clk);
		put(mk(0, 15));
		await(2'b01, 3);
		put(mk(30, 80));
		await(2'b00, 2);
		put(mk(0, 15));
		await(2'b01, 3);
		put(mk(125, 50));
		await(2'b00, 4);
		put(mk(0, 15));
		await(2'b01, 3);
		put('{16'h0096, 16'h0096, 16'h00d2});
		await(2'b00, 0);
		put(mk(0, 15));
		await(2'b01, 3);
		put(mk(30, 80));
		repeat (TK - 2) @(posedge clk);
		put(mk(125, 50));
		repeat (2 * TK) @(posedge clk);
		put(mk(30, 80));
		await(2'b00, 2);
		$display("test timers done");
		bus(1'b1, OFS_START, 32'h0);
		bus(1'b1, OFS_MINH, 32'h0);
		put(mk(0, 15));
		await(2'b01, 0);
		put(mk(30, 80));
		await(2'b00, 0);
		bus(1'b1, OFS_MINH, 32'h14);
		cmd_blk <= 1'b1;
		repeat (TK) @(posedge clk);
		put(mk(0, 15));
		await(2'b10, 0);
		put(mk(30, 80));
		await(2'b00, 0);
		cmd_blk <= 1'b0;
		repeat (TK) @(posedge clk);
		put(mk(0, 15));
		await(2'b01, 0);
		put(mk(30, 80));
		repeat (2 * TK) @(posedge clk);
		cmd_blk <= 1'b1;
		await(2'b00, 0);
		repeat (2 * TK) @(posedge clk);
		cmd_blk <= 1'b0;
		$display("test blocking done");
		// Frozen clock enable must hold every output still
		ce <= 1'b0;
		repeat (3 * TK) @(posedge clk);
		ce <= 1'b1;
		$display("test clock enable done");
		rd(OFS_ACTCNT, 32'(n_act));
		rd(OFS_BLKCNT, 32'(n_blk));
		bus(1'b1, OFS_ACTCNT, 32'h0);
		rd(OFS_ACTCNT, 32'h0);
		$display("test counters done");
		repeat (4) @(posedge clk);
		test_done;
	end
endmodule
